//--- bench/magnetometer_interrupt_selftest_tb_top.sv
// self-checking bench for the magnetometer interrupt block
`timescale 1ns/1ps
module magnetometer_interrupt_selftest_tb_top;
  import mist_pkg::*;
  typedef struct packed {
    logic [12:0] x;
    logic [12:0] y;
    logic [14:0] z;
    logic [2:0] o;
    logic [7:0] st;
  } mist_row_t;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, txn_end, sv = 1'b0, ma = 1'b0, std = 1'b0;
  logic [12:0] xv = 13'h0, yv = 13'h0;
  logic [14:0] zv = 15'h0;
  logic [13:0] res = 14'h0;
  logic [2:0] ovf = 3'h0, stp = 3'h0;
  logic st_req, cp, cn, io, io_n, ro, ro_n;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  // a saturated z axis sits below the low threshold: only x and y are exempt
  mist_row_t rows [7] = '{
    '{13'h0000, 13'h0000, 15'h0000, 3'h0, 8'h02},
    '{13'h1eff, 13'h0000, 15'h0000, 3'h0, 8'h03},
    '{13'h1f00, 13'h0101, 15'h0000, 3'h0, 8'h22},
    '{13'h1000, 13'h0000, 15'h7eff, 3'h0, 8'h0a},
    '{13'h012c, 13'h1ed4, 15'h0101, 3'h0, 8'h96},
    '{13'h0000, 13'h0000, 15'h0005, 3'h4, 8'h4a},
    '{13'h0005, 13'h0000, 15'h0000, 3'h1, 8'h42}};
  logic [7:0] rst_a [6] = '{8'h4c, 8'h4d, 8'h4e, 8'h4f, 8'h50, 8'h4a};
  logic [7:0] rst_v [6] = '{8'h06, 8'h3f, 8'h05, 8'h00, 8'h00, 8'h02};
  always #2 sys_clk = ~sys_clk;
  mist_host host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .txn_end(txn_end), .reg_rdata(reg_rdata));
  mist_core dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .txn_end(txn_end), .reg_rdata(reg_rdata),
    .meas_active(ma), .sample_valid(sv), .x_axis_value(xv), .y_axis_value(yv), .z_axis_value(zv),
    .plate_resistance_value(res), .axis_ovf(ovf), .selftest_done(std), .selftest_pass(stp),
    .selftest_req(st_req), .coil_pos_on(cp), .coil_neg_on(cn), .int_out(io), .int_oe_n(io_n),
    .sample_ready_out(ro), .sample_ready_oe_n(ro_n));
  task automatic tally_and_finish();
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic smp(input logic [12:0] x, input logic [12:0] y, input logic [14:0] z, input logic [2:0] o);
    @(negedge sys_clk);
    xv = x;
    yv = y;
    zv = z;
    ovf = o;
    res = res + 14'h0a53;
    sv = 1'b1;
    @(negedge sys_clk);
    sv = 1'b0;
    ovf = ~o;
    @(negedge sys_clk);
  endtask
  // cut a hang short well past the expected run length
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(negedge sys_clk);
    nrst = 1'b1;
    host.wr(ADDR_LOW_FIELD_THRESHOLD, 8'hf0);
    host.wr(ADDR_HIGH_FIELD_THRESHOLD, 8'h10);
    host.wr(ADDR_INT_ENABLE, 8'h40);
    host.wr(ADDR_PIN_CTRL, 8'h45);
    host.rd(ADDR_LOW_FIELD_THRESHOLD, d);
    chk(d, 8'hf0);
    foreach (rows[i]) begin
      smp(rows[i].x, rows[i].y, rows[i].z, rows[i].o);
      chk({6'h0, io_n, io}, {7'h0, rows[i].st != 8'h02});
      host.rd(ADDR_INT_STATUS, d);
      chk(d, rows[i].st);
      @(negedge sys_clk);
      chk({7'h0, io}, 8'h00);
    end
    chk({7'h0, ro_n}, 8'h01);
    host.rd(ADDR_X_MSB, d);
    chk(d, 8'h80);
    host.rd(ADDR_R_LSB, d);
    chk(d & 8'h01, 8'h01);
    host.rd(ADDR_R_MSB, d);
    chk(d, res[13:6]);
    host.close();
    host.rd(ADDR_R_LSB, d);
    chk(d & 8'h01, 8'h00);
    host.close();
    // a disabled source drops out at the next sample even while latched
    smp(13'h1eff, 13'h0, 15'h0, 3'h0);
    host.wr(ADDR_INT_ENABLE, 8'h41);
    smp(13'h1eff, 13'h0, 15'h0, 3'h0);
    host.rd(ADDR_INT_STATUS, d);
    chk(d, 8'h02);
    // non-latched with both pins active low
    host.wr(ADDR_INT_STATUS, 8'h00);
    host.wr(ADDR_INT_ENABLE, 8'h40);
    host.wr(ADDR_PIN_CTRL, 8'hc0);
    smp(13'h1eff, 13'h0, 15'h0, 3'h0);
    chk({4'h0, io_n, io, ro_n, ro}, 8'h00);
    smp(13'h0, 13'h0, 15'h0, 3'h0);
    chk({7'h0, io}, 8'h01);
    host.rd(ADDR_INT_STATUS, d);
    chk(d, 8'h00);
    // overflow still lands in status, but its pin enable is off
    host.wr(ADDR_INT_ENABLE, 8'h3f);
    smp(13'h0, 13'h0, 15'h0, 3'h1);
    chk({7'h0, io}, 8'h01);
    host.rd(ADDR_INT_STATUS, d);
    chk(d, 8'h40);
    host.rd(ADDR_Z_MSB, d);
    host.close();
    @(negedge sys_clk);
    chk({7'h0, ro}, 8'h01);
    host.start_selftest();
    for (int i = 0; i < 8 && st_req !== 1'b1; i++) begin
      @(negedge sys_clk);
    end
    chk({7'h0, st_req}, 8'h01);
    std = 1'b1;
    stp = 3'b101;
    @(negedge sys_clk);
    std = 1'b0;
    stp = 3'b010;
    host.rd(ADDR_OP_CTRL, d);
    chk(d, 8'h06);
    host.rd(ADDR_X_LSB, d);
    chk(d & 8'h01, 8'h01);
    host.rd(ADDR_Y_LSB, d);
    chk(d & 8'h01, 8'h00);
    host.rd(ADDR_Z_LSB, d);
    chk(d & 8'h01, 8'h01);
    host.close();
    for (int c = 0; c < 4; c++) begin
      host.coil_set(c[1:0]);
      ma = 1'b1;
      repeat (2) @(negedge sys_clk);
      chk({6'h0, cp, cn}, {6'h0, c == 3, c == 2});
      ma = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk({6'h0, cp, cn}, 8'h00);
    end
    host.coil_set(MIST_COIL_OFF);
    // second reset in mid-run restores the register defaults
    @(negedge sys_clk);
    nrst = 1'b0;
    repeat (5) @(negedge sys_clk);
    nrst = 1'b1;
    chk({6'h0, io_n, ro_n}, 8'h03);
    foreach (rst_a[i]) begin
      host.rd(rst_a[i], d);
      chk(d, rst_v[i]);
    end
    host.wr(ADDR_X_MSB, 8'hff);
    host.rd(ADDR_X_MSB, d);
    chk(d, 8'h00);
    host.rd(8'h60, d);
    chk(d, 8'h00);
    host.close();
    tally_and_finish();
  end
endmodule

//--- bench/mist_host.sv
// host model for the register port of the interrupt block
`timescale 1ns/1ps
module mist_host
  import mist_pkg::*;
(
  input wire logic sys_clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  output logic txn_end,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    txn_end = 1'b0;
  end
  // requests change at the falling edge and last one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
  task automatic close();
    @(negedge sys_clk);
    txn_end = 1'b1;
    @(negedge sys_clk);
    txn_end = 1'b0;
  endtask
  // sleep is entered before the start bit is set
  task automatic start_selftest();
    wr(ADDR_OP_CTRL, 8'h06);
    wr(ADDR_OP_CTRL, 8'h07);
  endtask
  // the coil field is only ever returned to off by the host
  task automatic coil_set(input logic [1:0] c);
    wr(ADDR_OP_CTRL, {c, 6'h06});
  endtask
endmodule

//--- logic/mist_axis_cmp.sv
// threshold comparison for one signed axis value
`timescale 1ns/1ps
module mist_axis_cmp
  import mist_pkg::*;
#(
  parameter int W = 13,
  parameter bit SKIP_OVF = 1'b1
) (
  input wire logic [W-1:0] value,
  input wire logic [7:0] low_thr,
  input wire logic [7:0] high_thr,
  output logic low_hit,
  output logic high_hit
);
  logic signed [15:0] val_ext;
  logic signed [15:0] low_lvl;
  logic signed [15:0] high_lvl;
  logic is_ovf_code;

  assign val_ext = 16'(signed'(value));
  // both thresholds are scaled by 16 to meet the raw data range
  assign low_lvl = 16'(signed'({low_thr, 4'h0}));
  assign high_lvl = 16'(signed'({high_thr, 4'h0}));
  assign is_ovf_code = SKIP_OVF && (value == {1'b1, {(W-1){1'b0}}});
  // the saturated overflow code sits below any threshold; keep it out
  assign low_hit = (val_ext < low_lvl) && !is_ovf_code;
  assign high_hit = val_ext > high_lvl;
endmodule

//--- logic/mist_core.sv
// magnetometer interrupt engine and self-test control
// Operation
// - self-test end clears start bit and reports per-axis pass bits.
// - coil field 00 normal, 10 negative, 11 positive, 01 reserved.
// - coil current only during active measurement, in any operating mode.
// - six per-axis threshold sources and overflow set status bits at 0x4A.
// - interrupt pin carries threshold and overflow events only when enabled.
// - sample-ready event goes only to its own pin, when enabled.
// - six active-low per-axis enables gate the threshold detection.
// - status bits update with each new sample set written.
// - disabled source clears its status and pin after next measurement.
// - non-latched clears on next sample; latched clears on status read.
// - latch bit selects latched or non-latched for all but data ready.
// - data ready is non-latched: set on new set, cleared after readout.
// - polarity bits select active high (default) or active low.
// - pins are push-pull when enabled, floating otherwise.
// - each axis below low threshold sets its low status bit.
// - X or Y overflow code never raises a low-threshold event.
// - axis above high threshold times 16 sets its high status bit.
// - overflowed axis data saturates to its most negative value.
// - any overflow sets shared bit; pin only with overflow enable.
// - data ready clears when a data read's transaction closes.
`timescale 1ns/1ps
module mist_core
  import mist_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic txn_end,
  output logic [7:0] reg_rdata,
  input wire logic meas_active,
  input wire logic sample_valid,
  input wire logic [12:0] x_axis_value,
  input wire logic [12:0] y_axis_value,
  input wire logic [14:0] z_axis_value,
  input wire logic [13:0] plate_resistance_value,
  input wire logic [2:0] axis_ovf,
  input wire logic selftest_done,
  input wire logic [2:0] selftest_pass,
  output logic selftest_req,
  output logic coil_pos_on,
  output logic coil_neg_on,
  output logic int_out,
  output logic int_oe_n,
  output logic sample_ready_out,
  output logic sample_ready_oe_n
);
  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic [7:0] op_ctrl_reg;
  logic [7:0] int_enable_reg;
  logic [7:0] pin_ctrl_reg;
  logic [7:0] low_field_threshold_reg;
  logic [7:0] high_field_threshold_reg;
  logic latch_reg;
  logic [2:0] st_pass_reg;
  mist_st_state_t st_state_reg;
  mist_coil_t coil_test_field;
  logic [1:0] operating_mode_field;
  logic wr_op;
  logic st_finish;

  assign coil_test_field = mist_coil_t'(op_ctrl_reg[OPC_COIL_LO +: 2]);
  assign operating_mode_field = op_ctrl_reg[OPC_MODE_LO +: 2];
  assign wr_op = reg_wr && (reg_addr == ADDR_OP_CTRL);
  assign st_finish = (st_state_reg == MIST_ST_RUN) && selftest_done;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      op_ctrl_reg <= RST_OP_CTRL;
    end else begin
      if (wr_op) begin
        op_ctrl_reg <= reg_wdata;
      end
      // the coil field is left alone here: only a host write changes it
      if (st_finish) begin
        op_ctrl_reg[OPC_SELFTEST_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      int_enable_reg <= RST_INT_ENABLE;
      pin_ctrl_reg <= RST_PIN_CTRL;
      low_field_threshold_reg <= RST_THRESHOLD;
      high_field_threshold_reg <= RST_THRESHOLD;
      latch_reg <= RST_LATCH;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_INT_ENABLE: int_enable_reg <= reg_wdata;
        ADDR_PIN_CTRL: pin_ctrl_reg <= reg_wdata;
        ADDR_LOW_FIELD_THRESHOLD: low_field_threshold_reg <= reg_wdata;
        ADDR_HIGH_FIELD_THRESHOLD: high_field_threshold_reg <= reg_wdata;
        ADDR_INT_STATUS: latch_reg <= reg_wdata[STS_LATCH];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // self-test sequencing
  // ---------------------------------------------------------------
  // the start bit is honoured in any mode; sleep entry is the host's duty
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_state_reg <= MIST_ST_IDLE;
      st_pass_reg <= 3'h0;
      selftest_req <= 1'b0;
    end else begin
      selftest_req <= 1'b0;
      case (st_state_reg)
        MIST_ST_IDLE: begin
          if (op_ctrl_reg[OPC_SELFTEST_BIT]) begin
            st_state_reg <= MIST_ST_RUN;
            selftest_req <= 1'b1;
          end
        end
        MIST_ST_RUN: begin
          if (selftest_done) begin
            st_pass_reg <= selftest_pass;
            st_state_reg <= MIST_ST_DONE;
          end
        end
        MIST_ST_DONE: st_state_reg <= MIST_ST_IDLE;
        default: st_state_reg <= MIST_ST_IDLE;
      endcase
    end
  end

  // coil current follows the measurement phase, whatever the mode
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      coil_pos_on <= 1'b0;
      coil_neg_on <= 1'b0;
    end else begin
      coil_pos_on <= meas_active && (coil_test_field == MIST_COIL_POS);
      coil_neg_on <= meas_active && (coil_test_field == MIST_COIL_NEG);
    end
  end

  // ---------------------------------------------------------------
  // data shadowing
  // ---------------------------------------------------------------
  // a sample arriving mid-read waits in the shadow so an axis never mixes
  logic rd_block_reg;
  logic shadow_pend_reg;
  logic [12:0] sh_x_reg;
  logic [12:0] sh_y_reg;
  logic [14:0] sh_z_reg;
  logic [13:0] sh_r_reg;
  logic [2:0] sh_ovf_reg;
  logic data_rd;
  logic blocked;
  logic commit;
  logic use_live;
  logic [12:0] c_x;
  logic [12:0] c_y;
  logic [14:0] c_z;
  logic [13:0] c_r;
  logic [2:0] c_ovf;

  assign data_rd = reg_rd && (reg_addr >= ADDR_X_LSB) && (reg_addr <= ADDR_R_MSB);
  assign blocked = (rd_block_reg || data_rd) && !txn_end;
  assign use_live = sample_valid && !blocked;
  assign commit = use_live || (txn_end && shadow_pend_reg);
  assign c_ovf = use_live ? axis_ovf : sh_ovf_reg;
  assign c_r = use_live ? plate_resistance_value : sh_r_reg;
  // saturate overflowed axes before they reach the compare or the registers
  assign c_x = c_ovf[0] ? XY_OVF_CODE : (use_live ? x_axis_value : sh_x_reg);
  assign c_y = c_ovf[1] ? XY_OVF_CODE : (use_live ? y_axis_value : sh_y_reg);
  assign c_z = c_ovf[2] ? Z_OVF_CODE : (use_live ? z_axis_value : sh_z_reg);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rd_block_reg <= 1'b0;
      shadow_pend_reg <= 1'b0;
      sh_x_reg <= 13'h0;
      sh_y_reg <= 13'h0;
      sh_z_reg <= 15'h0;
      sh_r_reg <= 14'h0;
      sh_ovf_reg <= 3'h0;
    end else begin
      if (txn_end) begin
        rd_block_reg <= 1'b0;
      end else if (data_rd) begin
        rd_block_reg <= 1'b1;
      end
      if (sample_valid && blocked) begin
        shadow_pend_reg <= 1'b1;
        sh_x_reg <= x_axis_value;
        sh_y_reg <= y_axis_value;
        sh_z_reg <= z_axis_value;
        sh_r_reg <= plate_resistance_value;
        sh_ovf_reg <= axis_ovf;
      end else if (commit) begin
        shadow_pend_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // data registers and data ready
  // ---------------------------------------------------------------
  logic [12:0] x_data_reg;
  logic [12:0] y_data_reg;
  logic [14:0] z_data_reg;
  logic [13:0] r_data_reg;
  logic sample_ready_event;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      x_data_reg <= 13'h0;
      y_data_reg <= 13'h0;
      z_data_reg <= 15'h0;
      r_data_reg <= 14'h0;
    end else if (commit) begin
      x_data_reg <= c_x;
      y_data_reg <= c_y;
      z_data_reg <= c_z;
      r_data_reg <= c_r;
    end
  end

  // a fresh set in the closing cycle wins over the readout clear
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sample_ready_event <= 1'b0;
    end else if (commit) begin
      sample_ready_event <= 1'b1;
    end else if (txn_end && rd_block_reg) begin
      sample_ready_event <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // threshold and overflow status
  // ---------------------------------------------------------------
  logic [2:0] low_hit;
  logic [2:0] high_hit;
  logic [2:0] low_en;
  logic [2:0] high_en;
  logic [7:0] status_reg;
  logic [7:0] src_en;
  logic [7:0] new_hits;
  logic [7:0] status_next;
  logic sts_rd;

  mist_axis_cmp #(.W(13), .SKIP_OVF(1'b1)) u_cmp_x (
    .value(c_x),
    .low_thr(low_field_threshold_reg),
    .high_thr(high_field_threshold_reg),
    .low_hit(low_hit[0]),
    .high_hit(high_hit[0])
  );
  mist_axis_cmp #(.W(13), .SKIP_OVF(1'b1)) u_cmp_y (
    .value(c_y),
    .low_thr(low_field_threshold_reg),
    .high_thr(high_field_threshold_reg),
    .low_hit(low_hit[1]),
    .high_hit(high_hit[1])
  );
  mist_axis_cmp #(.W(15), .SKIP_OVF(1'b0)) u_cmp_z (
    .value(c_z),
    .low_thr(low_field_threshold_reg),
    .high_thr(high_field_threshold_reg),
    .low_hit(low_hit[2]),
    .high_hit(high_hit[2])
  );

  assign low_en = ~int_enable_reg[2:0];
  assign high_en = ~int_enable_reg[5:3];
  assign sts_rd = reg_rd && (reg_addr == ADDR_INT_STATUS);
  // overflow is always flagged in status; its enable only gates the pin
  assign src_en = {high_en[2], 1'b1, high_en[1], high_en[0], low_en[2], low_en[1], 1'b0, low_en[0]};
  assign new_hits = {high_hit[2], |c_ovf, high_hit[1], high_hit[0],
                     low_hit[2], low_hit[1], 1'b0, low_hit[0]} & src_en;

  always_comb begin
    status_next = status_reg;
    if (commit) begin
      if (!latch_reg || sts_rd) begin
        status_next = new_hits;
      end else begin
        status_next = (status_reg & src_en) | new_hits;
      end
    end else if (sts_rd && latch_reg) begin
      status_next = 8'h00;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      status_reg <= 8'h00;
    end else begin
      status_reg <= status_next;
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  logic int_active;
  logic [7:0] pin_mask;

  assign pin_mask = {1'b1, int_enable_reg[ENA_OVF], 6'h3f};
  assign int_active = |(status_reg & pin_mask);

  mist_pin_drv u_int_pin (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .active(int_active),
    .pin_en(pin_ctrl_reg[PIN_INT_EN]),
    .polarity(pin_ctrl_reg[PIN_INT_POL]),
    .pin_out(int_out),
    .pin_oe_n(int_oe_n)
  );
  mist_pin_drv u_ready_pin (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .active(sample_ready_event),
    .pin_en(pin_ctrl_reg[PIN_SAMPLE_READY_EVENT_EN]),
    .polarity(pin_ctrl_reg[PIN_SAMPLE_READY_EVENT_POL]),
    .pin_out(sample_ready_out),
    .pin_oe_n(sample_ready_oe_n)
  );

  // ---------------------------------------------------------------
  // register read path
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_X_LSB: reg_rdata <= {x_data_reg[4:0], 2'b00, st_pass_reg[0]};
        ADDR_X_MSB: reg_rdata <= x_data_reg[12:5];
        ADDR_Y_LSB: reg_rdata <= {y_data_reg[4:0], 2'b00, st_pass_reg[1]};
        ADDR_Y_MSB: reg_rdata <= y_data_reg[12:5];
        ADDR_Z_LSB: reg_rdata <= {z_data_reg[6:0], st_pass_reg[2]};
        ADDR_Z_MSB: reg_rdata <= z_data_reg[14:7];
        ADDR_R_LSB: reg_rdata <= {r_data_reg[5:0], 1'b0, sample_ready_event};
        ADDR_R_MSB: reg_rdata <= r_data_reg[13:6];
        ADDR_INT_STATUS: reg_rdata <= {status_reg[7:2], latch_reg, status_reg[0]};
        ADDR_OP_CTRL: reg_rdata <= op_ctrl_reg;
        ADDR_INT_ENABLE: reg_rdata <= int_enable_reg;
        ADDR_PIN_CTRL: reg_rdata <= pin_ctrl_reg;
        ADDR_LOW_FIELD_THRESHOLD: reg_rdata <= low_field_threshold_reg;
        ADDR_HIGH_FIELD_THRESHOLD: reg_rdata <= high_field_threshold_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_st_end;
    st_state_reg == MIST_ST_RUN && selftest_done && !wr_op;
  endsequence
  property p_st_clear;
    @(posedge sys_clk) disable iff (!nrst) s_st_end |=> !op_ctrl_reg[OPC_SELFTEST_BIT];
  endproperty
  a_st_clear: assert property (p_st_clear) else $error("self-test start bit not cleared");
  property p_st_pass;
    @(posedge sys_clk) disable iff (!nrst) s_st_end |=> st_pass_reg == $past(selftest_pass);
  endproperty
  a_st_pass: assert property (p_st_pass) else $error("self-test pass bits wrong");
  property p_coil_pos;
    @(posedge sys_clk) disable iff (!nrst)
      meas_active && coil_test_field == MIST_COIL_POS |=> coil_pos_on && !coil_neg_on;
  endproperty
  a_coil_pos: assert property (p_coil_pos) else $error("positive coil not driven");
  property p_coil_idle;
    @(posedge sys_clk) disable iff (!nrst)
      !meas_active || coil_test_field == MIST_COIL_OFF |=> !coil_pos_on && !coil_neg_on;
  endproperty
  a_coil_idle: assert property (p_coil_idle) else $error("coil on outside measurement");
  property p_ready_set;
    @(posedge sys_clk) disable iff (!nrst) commit |=> sample_ready_event;
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("data ready not set");
  property p_saturate;
    @(posedge sys_clk) disable iff (!nrst) use_live && axis_ovf[2] |=> z_data_reg == Z_OVF_CODE;
  endproperty
  a_saturate: assert property (p_saturate) else $error("z overflow not saturated");
  property p_ovf_flag;
    @(posedge sys_clk) disable iff (!nrst) commit && |c_ovf |=> status_reg[STS_OVF];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow status not set");
  property p_latch_clear;
    @(posedge sys_clk) disable iff (!nrst) sts_rd && latch_reg && !commit |=> status_reg == 8'h00;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("status read did not clear");
  property p_int_float;
    @(posedge sys_clk) disable iff (!nrst) !pin_ctrl_reg[PIN_INT_EN] [*2] |-> int_oe_n;
  endproperty
  a_int_float: assert property (p_int_float) else $error("interrupt pin driven while off");
endmodule

//--- logic/mist_pin_drv.sv
// push-pull interrupt pin with polarity and float control
`timescale 1ns/1ps
module mist_pin_drv (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic active,
  input wire logic pin_en,
  input wire logic polarity,
  output logic pin_out,
  output logic pin_oe_n
);
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pin_out <= 1'b0;
      pin_oe_n <= 1'b1;
    end else begin
      pin_out <= polarity ? active : !active;
      pin_oe_n <= !pin_en;
    end
  end
endmodule

//--- logic/mist_pkg.sv
// shared constants for the magnetometer interrupt and self-test block
package mist_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_X_LSB = 8'h42;
  localparam logic [7:0] ADDR_X_MSB = 8'h43;
  localparam logic [7:0] ADDR_Y_LSB = 8'h44;
  localparam logic [7:0] ADDR_Y_MSB = 8'h45;
  localparam logic [7:0] ADDR_Z_LSB = 8'h46;
  localparam logic [7:0] ADDR_Z_MSB = 8'h47;
  localparam logic [7:0] ADDR_R_LSB = 8'h48;
  localparam logic [7:0] ADDR_R_MSB = 8'h49;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h4a;
  localparam logic [7:0] ADDR_OP_CTRL = 8'h4c;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h4d;
  localparam logic [7:0] ADDR_PIN_CTRL = 8'h4e;
  localparam logic [7:0] ADDR_LOW_FIELD_THRESHOLD = 8'h4f;
  localparam logic [7:0] ADDR_HIGH_FIELD_THRESHOLD = 8'h50;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int OPC_SELFTEST_BIT = 0;
  localparam int OPC_MODE_LO = 1;
  localparam int OPC_COIL_LO = 6;
  localparam int STS_LOW_X = 0;
  localparam int STS_LATCH = 1;
  localparam int STS_LOW_Y = 2;
  localparam int STS_LOW_Z = 3;
  localparam int STS_HIGH_X = 4;
  localparam int STS_HIGH_Y = 5;
  localparam int STS_OVF = 6;
  localparam int STS_HIGH_Z = 7;
  localparam int ENA_OVF = 6;
  localparam int PIN_INT_POL = 0;
  localparam int PIN_SAMPLE_READY_EVENT_POL = 2;
  localparam int PIN_INT_EN = 6;
  localparam int PIN_SAMPLE_READY_EVENT_EN = 7;
  // ---------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_SLEEP = 2'b11;
  localparam logic [7:0] RST_OP_CTRL = 8'h06;
  localparam logic [7:0] RST_INT_ENABLE = 8'h3f;
  localparam logic [7:0] RST_PIN_CTRL = 8'h05;
  localparam logic [7:0] RST_THRESHOLD = 8'h00;
  localparam logic RST_LATCH = 1'b1;
  localparam logic [12:0] XY_OVF_CODE = 13'h1000;
  localparam logic [14:0] Z_OVF_CODE = 15'h4000;
  typedef enum logic [1:0] {
    MIST_COIL_OFF = 2'b00,
    MIST_COIL_RSVD = 2'b01,
    MIST_COIL_NEG = 2'b10,
    MIST_COIL_POS = 2'b11
  } mist_coil_t;
  typedef enum logic [1:0] {
    MIST_ST_IDLE = 2'b00,
    MIST_ST_RUN = 2'b01,
    MIST_ST_DONE = 2'b10
  } mist_st_state_t;
endpackage
